// ===== include/mtc_defs.svh
/*
 * constants of the magnetic threshold comparator: register addresses,
 * field positions, factory values and timing counts.
 * assumes a 16-bit word register port and a 200 MHz core clock.
 */
`ifndef MTC_DEFS_SVH
`define MTC_DEFS_SVH

`define MTC_AW            8
`define MTC_DW            16

`define MTC_A_FIELD       8'h00
`define MTC_A_TEMP        8'h01
`define MTC_A_STATE       8'h02
`define MTC_A_IRQ_STS     8'h08
`define MTC_A_IRQ_MSK     8'h09
`define MTC_A_RB_T1       8'h10
`define MTC_A_RB_H1       8'h11
`define MTC_A_RB_T2       8'h12
`define MTC_A_RB_H2       8'h13
`define MTC_A_RB_INV      8'h14
`define MTC_A_RB_OFS      8'h15
`define MTC_A_RB_FLT      8'h16
`define MTC_A_RB_MODE     8'h17
`define MTC_A_WR_T1       8'h30
`define MTC_A_WR_H1       8'h31
`define MTC_A_WR_T2       8'h32
`define MTC_A_WR_H2       8'h33
`define MTC_A_WR_INV      8'h34
`define MTC_A_WR_OFS      8'h35
`define MTC_A_WR_FLT      8'h36
`define MTC_A_WR_MODE     8'h37
`define MTC_RB_DELTA      8'h20

`define MTC_IRQ_RISE      0
`define MTC_IRQ_FALL      1
`define MTC_IRQ_SAMPLE    2
`define MTC_IRQ_W         3

`define MTC_RST_T1        16'hFF9C
`define MTC_RST_H1        16'h000A
`define MTC_RST_T2        16'h0064
`define MTC_RST_H2        16'h000A
`define MTC_RST_OFS       16'h0000
`define MTC_RST_FLT       7'h01
`define MTC_FLT_MIN       7'h01
`define MTC_FLT_MAX       7'h7F

`define MTC_CLK_MHZ       200
`define MTC_LINK_NS       64
`define MTC_LINK_CYC      ((`MTC_LINK_NS * `MTC_CLK_MHZ) / 1000)

`endif

// ===== include/mtc_pkg.sv
/*
 * types of the magnetic threshold comparator.
 * assumes mtc_defs.svh for all numeric constants.
 */
`default_nettype none

package mtc_pkg;
    typedef enum logic [1:0] {
        MTC_OMNI,
        MTC_UNI,
        MTC_BI
    } mtc_mode_t;
endpackage

`default_nettype wire

// ===== rtl/mtc_core.sv
/*
 * magnetic threshold comparator: parameter store, offset correction,
 * first-order low-pass filter, hysteresis comparator, interrupt status and
 * the register port.
 * assumes field and temperature words held stable around each rising edge
 * of sample_clk, which comes from outside the clock domain.
 */
// The address-and-strobe port was left to the implementer.
`include "mtc_defs.svh"

`default_nettype none

module mtc_core #(
    parameter int DW = `MTC_DW,
    parameter int AW = `MTC_AW
) (
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire logic          por_n,
    input  wire logic          clk_en,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [DW-1:0] reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [DW-1:0] reg_rdata,
    input  wire logic          sample_clk,
    input  wire logic [DW-1:0] field_raw,
    input  wire logic [DW-1:0] temp_raw,
    output logic               thr_out,
    output logic               irq
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (DW != 16) begin : g_dw_chk
        $error("mtc_core serves 16-bit words only");
    end
    if (AW < 6) begin : g_aw_chk
        $error("mtc_core needs an address of at least 6 bits");
    end

    // ----------------------------------------------------------------
    // parameter store
    // ----------------------------------------------------------------
    // held by por_n only: rstn leaves the settings alone, which stands
    // in for the nonvolatile copy kept across power cycles
    logic signed [15:0] t1_q;
    logic signed [15:0] h1_q;
    logic signed [15:0] t2_q;
    logic signed [15:0] h2_q;
    logic signed [15:0] ofs_q;
    logic        [6:0]  flt_q;
    logic               inv_q;
    mtc_pkg::mtc_mode_t mode_q;

    logic wr_t1;
    logic wr_h1;
    logic wr_t2;
    logic wr_h2;
    logic wr_inv;
    logic wr_ofs;
    logic wr_flt;
    logic wr_mode;
    logic wr_sts;
    logic wr_msk;

    assign wr_t1   = reg_wr && reg_addr == `MTC_A_WR_T1;
    assign wr_h1   = reg_wr && reg_addr == `MTC_A_WR_H1;
    assign wr_t2   = reg_wr && reg_addr == `MTC_A_WR_T2;
    assign wr_h2   = reg_wr && reg_addr == `MTC_A_WR_H2;
    assign wr_inv  = reg_wr && reg_addr == `MTC_A_WR_INV;
    assign wr_ofs  = reg_wr && reg_addr == `MTC_A_WR_OFS;
    assign wr_flt  = reg_wr && reg_addr == `MTC_A_WR_FLT;
    assign wr_mode = reg_wr && reg_addr == `MTC_A_WR_MODE;
    assign wr_sts  = reg_wr && reg_addr == `MTC_A_IRQ_STS;
    assign wr_msk  = reg_wr && reg_addr == `MTC_A_IRQ_MSK;

    // negative hysteresis would turn the comparator inside out: refused
    logic hyst_ok;
    logic flt_ok;
    logic mode_ok;

    assign hyst_ok = !reg_wdata[15];
    assign flt_ok  = reg_wdata[15:7] == 9'h000 && reg_wdata[6:0] != 7'h00;
    assign mode_ok = reg_wdata[15:2] == 14'h0000 && reg_wdata[1:0] != 2'h3;

    always_ff @(posedge clock) begin
        if (!por_n) begin
            t1_q   <= `MTC_RST_T1;
            h1_q   <= `MTC_RST_H1;
            t2_q   <= `MTC_RST_T2;
            h2_q   <= `MTC_RST_H2;
        end else if (clk_en) begin
            if (wr_t1) begin
                t1_q <= reg_wdata;
            end
            if (wr_h1 && hyst_ok) begin
                h1_q <= reg_wdata;
            end
            if (wr_t2) begin
                t2_q <= reg_wdata;
            end
            if (wr_h2 && hyst_ok) begin
                h2_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!por_n) begin
            ofs_q  <= `MTC_RST_OFS;
            flt_q  <= `MTC_RST_FLT;
            inv_q  <= 1'b0;
            mode_q <= mtc_pkg::MTC_OMNI;
        end else if (clk_en) begin
            if (wr_ofs) begin
                ofs_q <= reg_wdata;
            end
            if (wr_flt && flt_ok) begin
                flt_q <= reg_wdata[6:0];
            end
            if (wr_inv) begin
                inv_q <= reg_wdata != 16'h0000;
            end
            if (wr_mode && mode_ok) begin
                mode_q <= mtc_pkg::mtc_mode_t'(reg_wdata[1:0]);
            end
        end
    end

    // ----------------------------------------------------------------
    // sample clock crossing
    // ----------------------------------------------------------------
    logic       sclk_s1_q;
    logic       sclk_s2_q;
    logic       sclk_s3_q;
    logic       sclk_lvl_q;
    logic       sample_go;
    logic [15:0] fld_s1_q;
    logic [15:0] fld_s2_q;
    logic [15:0] tmp_s1_q;
    logic [15:0] tmp_s2_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
        end else if (clk_en) begin
            sclk_s1_q <= sample_clk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
        end
    end

    // a level counts only once the second and third stages agree
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sclk_lvl_q <= 1'b0;
        end else if (clk_en && sclk_s2_q == sclk_s3_q) begin
            sclk_lvl_q <= sclk_s3_q;
        end
    end

    assign sample_go = clk_en && sclk_s2_q && sclk_s3_q && !sclk_lvl_q;

    // the words ride two stages so they are settled by the accepted edge
    always_ff @(posedge clock) begin
        if (!rstn) begin
            fld_s1_q <= 16'h0000;
            fld_s2_q <= 16'h0000;
            tmp_s1_q <= 16'h0000;
            tmp_s2_q <= 16'h0000;
        end else if (clk_en) begin
            fld_s1_q <= field_raw;
            fld_s2_q <= fld_s1_q;
            tmp_s1_q <= temp_raw;
            tmp_s2_q <= tmp_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // offset correction and filter
    // ----------------------------------------------------------------
    logic signed [16:0] corr_wide;
    logic signed [15:0] corr;
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic signed [15:0] field_q;
    logic signed [15:0] temp_q;
    logic               cmp_go_q;

    assign corr_wide = 17'(signed'(fld_s2_q)) - 17'(ofs_q);

    // saturate so a large offset cannot wrap the reading round
    always_comb begin
        if (corr_wide > 17'sh07FFF) begin
            corr = 16'sh7FFF;
        end else if (corr_wide < -17'sh08000) begin
            corr = -16'sh8000;
        end else begin
            corr = corr_wide[15:0];
        end
    end

    // y += (x - y) / k with k the filter constant; division truncates toward
    // zero, so the reading can stop up to k-1 counts short of a step input
    assign diff = 17'(corr) - 17'(field_q);
    assign step = diff / signed'({10'h000, flt_q});

    always_ff @(posedge clock) begin
        if (!rstn) begin
            field_q  <= 16'sh0000;
            temp_q   <= 16'sh0000;
            cmp_go_q <= 1'b0;
        end else if (clk_en) begin
            cmp_go_q <= sample_go;
            if (sample_go) begin
                temp_q <= tmp_s2_q;
                if (flt_q == `MTC_FLT_MIN) begin
                    field_q <= corr;
                end else begin
                    field_q <= 16'(17'(field_q) + step);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // comparator
    // ----------------------------------------------------------------
    logic signed [17:0] fe;
    logic signed [17:0] t1e;
    logic signed [17:0] t2e;
    logic signed [17:0] off1_pos;
    logic signed [17:0] off1_neg;
    logic signed [17:0] off2_pos;
    logic               pos_q;
    logic               neg_q;
    logic               pos_d;
    logic               neg_d;
    logic               state;

    assign fe       = 18'(field_q);
    assign t1e      = 18'(t1_q);
    assign t2e      = 18'(t2_q);
    assign off1_pos = t1e - 18'(h1_q);
    assign off1_neg = t1e + 18'(h1_q);
    assign off2_pos = t2e - 18'(h2_q);

    always_comb begin
        pos_d = pos_q;
        neg_d = neg_q;
        case (mode_q)
            mtc_pkg::MTC_OMNI: begin
                // positive side on pair two, negative side on pair one
                if (fe > t2e) begin
                    pos_d = 1'b1;
                end else if (fe <= off2_pos) begin
                    pos_d = 1'b0;
                end
                if (fe < t1e) begin
                    neg_d = 1'b1;
                end else if (fe >= off1_neg) begin
                    neg_d = 1'b0;
                end
            end
            mtc_pkg::MTC_UNI, mtc_pkg::MTC_BI: begin
                // same law for both; only hysteresis against |t1| differs,
                // which decides whether the release point crosses zero
                neg_d = 1'b0;
                if (!t1_q[15]) begin
                    if (fe > t1e) begin
                        pos_d = 1'b1;
                    end else if (fe <= off1_pos) begin
                        pos_d = 1'b0;
                    end
                end else begin
                    if (fe < t1e) begin
                        pos_d = 1'b1;
                    end else if (fe >= off1_neg) begin
                        pos_d = 1'b0;
                    end
                end
            end
            default: begin
                pos_d = 1'b0;
                neg_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pos_q <= 1'b0;
            neg_q <= 1'b0;
        end else if (clk_en && cmp_go_q) begin
            pos_q <= pos_d;
            neg_q <= neg_d;
        end
    end

    assign state = pos_q | neg_q;

    // pin and readable state leave the same flops
    always_ff @(posedge clock) begin
        if (!rstn) begin
            thr_out <= 1'b0;
        end else if (clk_en) begin
            thr_out <= state ^ inv_q;
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    logic [`MTC_IRQ_W-1:0] sts_q;
    logic [`MTC_IRQ_W-1:0] msk_q;
    logic [`MTC_IRQ_W-1:0] sts_set;
    logic [`MTC_IRQ_W-1:0] sts_clr;
    logic                  state_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state;
        end
    end

    always_comb begin
        sts_set                  = '0;
        sts_set[`MTC_IRQ_RISE]   = state && !state_q;
        sts_set[`MTC_IRQ_FALL]   = !state && state_q;
        sts_set[`MTC_IRQ_SAMPLE] = cmp_go_q;
    end

    assign sts_clr = wr_sts ? reg_wdata[`MTC_IRQ_W-1:0] : '0;

    // a new event beats a clear in the same cycle
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sts_q <= '0;
            msk_q <= '0;
        end else if (clk_en) begin
            sts_q <= (sts_q & ~sts_clr) | sts_set;
            if (wr_msk) begin
                msk_q <= reg_wdata[`MTC_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(sts_q & msk_q);

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        case (reg_addr)
            `MTC_A_FIELD:   rd_mux = field_q;
            `MTC_A_TEMP:    rd_mux = temp_q;
            `MTC_A_STATE:   rd_mux = {15'h0000, thr_out};
            `MTC_A_IRQ_STS: rd_mux = {13'h0000, sts_q};
            `MTC_A_IRQ_MSK: rd_mux = {13'h0000, msk_q};
            `MTC_A_RB_T1:   rd_mux = t1_q;
            `MTC_A_RB_H1:   rd_mux = h1_q;
            `MTC_A_RB_T2:   rd_mux = t2_q;
            `MTC_A_RB_H2:   rd_mux = h2_q;
            `MTC_A_RB_INV:  rd_mux = {15'h0000, inv_q};
            `MTC_A_RB_OFS:  rd_mux = ofs_q;
            `MTC_A_RB_FLT:  rd_mux = {9'h000, flt_q};
            `MTC_A_RB_MODE: rd_mux = {14'h0000, mode_q};
            default:        rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

endmodule

`default_nettype wire

// ===== sim/mtc_core_monitor.sv
/*
 * checker for mtc_core: register port answers and threshold output timing.
 * assumes it is bound onto mtc_core and sees only that module's ports.
 */
`default_nettype none

module mtc_core_monitor #(
    parameter int DW = 16,
    parameter int AW = 8
) (
    input wire logic          clock,
    input wire logic          rstn,
    input wire logic          por_n,
    input wire logic          clk_en,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire logic [DW-1:0] reg_rdata,
    input wire logic          sample_clk,
    input wire logic [DW-1:0] field_raw,
    input wire logic [DW-1:0] temp_raw,
    input wire logic          thr_out,
    input wire logic          irq
);
    logic       smp_q;
    logic [3:0] since_smp_q;
    logic [3:0] since_inv_q;
    logic       mask_nz_q;

    always_ff @(posedge clock) begin
        smp_q <= sample_clk;
    end
    // cycles since a sample edge was seen; saturates so it never wraps
    always_ff @(posedge clock) begin
        if (!rstn || (sample_clk && !smp_q)) since_smp_q <= 4'h0;
        else if (since_smp_q != 4'hF) since_smp_q <= since_smp_q + 4'h1;
    end
    always_ff @(posedge clock) begin
        if (!rstn || !por_n || (reg_wr && reg_addr == 8'h34)) since_inv_q <= 4'h0;
        else if (since_inv_q != 4'hF) since_inv_q <= since_inv_q + 4'h1;
    end
    always_ff @(posedge clock) begin
        if (!rstn) mask_nz_q <= 1'b0;
        else if (reg_wr && reg_addr == 8'h09) mask_nz_q <= |reg_wdata[2:0];
    end

    default clocking mcb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_wr_param;
        reg_wr && reg_addr inside {8'h30, 8'h32, 8'h35};
    endsequence
    sequence s_rd_mirror;
        reg_rd && reg_addr == $past(reg_addr) - 8'h20;
    endsequence

    a_readback_offset: assert property (s_wr_param ##1 s_rd_mirror |=>
        reg_rdata == $past(reg_wdata, 2)) else $error("readback differs from write");
    a_idle_rdata_zero: assert property ((clk_en && !reg_rd) ##1 clk_en |->
        reg_rdata == '0) else $error("read data without read");
    a_write_space_zero: assert property (reg_rd && reg_addr >= 8'h30 |=>
        reg_rdata == '0) else $error("write space read not zero");
    a_gap_read_zero: assert property (reg_rd && reg_addr inside
        {[8'h03:8'h07], [8'h0A:8'h0F], [8'h18:8'h2F]} |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    a_state_pin_match: assert property (reg_rd && reg_addr == 8'h02 |=>
        reg_rdata == {{(DW-1){1'b0}}, $past(thr_out)}) else $error("state differs from pin");
    a_hyst_sign_clear: assert property (reg_rd && reg_addr inside {8'h11, 8'h13} |=>
        !reg_rdata[DW-1]) else $error("negative hysteresis accepted");
    a_filter_in_range: assert property (reg_rd && reg_addr == 8'h16 |=>
        reg_rdata inside {[16'h0001:16'h007F]}) else $error("filter constant out of range");
    a_invert_one_bit: assert property (reg_rd && reg_addr == 8'h14 |=>
        reg_rdata[DW-1:1] == '0) else $error("invert readback wider than a bit");
    a_out_has_cause: assert property ($changed(thr_out) |->
        since_smp_q inside {[4'h3:4'h8]} || since_inv_q <= 4'h3)
        else $error("output moved without sample or invert");
    a_irq_needs_mask: assert property (irq |-> mask_nz_q)
        else $error("interrupt with all masks clear");
endmodule

`default_nettype wire

// ===== sim/mtc_core_tb.sv
/*
 * self-checking bench for mtc_core: register map, comparator modes, offset,
 * filter, inversion and interrupts.
 * assumes mtc_core, mtc_sensor_model and mtc_core_monitor are compiled first.
 */
`default_nettype none

module mtc_core_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock;
    logic        rstn;
    logic        por_n;
    logic        clk_en;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        sample_clk;
    logic [15:0] field_raw;
    logic [15:0] temp_raw;
    logic        thr_out;
    logic        irq;
    int          mismatches;
    int          checks_done;

    mtc_core i_mtc_core (.clock(clock), .rstn(rstn), .por_n(por_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sample_clk(sample_clk), .field_raw(field_raw),
        .temp_raw(temp_raw), .thr_out(thr_out), .irq(irq));
    mtc_sensor_model i_mtc_sensor_model (.sample_clk(sample_clk), .field_raw(field_raw),
        .temp_raw(temp_raw));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic smp(input logic [15:0] f, input logic [15:0] t);
        i_mtc_sensor_model.frame(f, t);
        repeat (12) @(posedge clock);
    endtask
    task automatic step(input logic [15:0] f, input logic e);
        smp(f, 16'h0019);
        #1 chk({15'h0000, thr_out}, {15'h0000, e});
        rc(8'h02, {15'h0000, e});
    endtask
    task automatic factory();
        @(posedge clock);
        por_n <= 1'b0;
        @(posedge clock);
        por_n <= 1'b1;
    endtask

    task automatic t_map();
        logic [15:0] wv [7];
        logic [15:0] rv [7];
        wv = '{16'h0032, 16'h0014, 16'h0050, 16'h000F, 16'h0007, 16'h0003, 16'h0009};
        rv = '{16'hFF9C, 16'h000A, 16'h0064, 16'h000A, 16'h0000, 16'h0000, 16'h0001};
        for (int i = 0; i < 7; i++) rc(8'h10 + 8'(i), rv[i]);
        rc(8'h17, 16'h0000);
        for (int i = 0; i < 7; i++) wr(8'h30 + 8'(i), wv[i]);
        wv[4] = 16'h0001;
        for (int i = 0; i < 7; i++) rc(8'h10 + 8'(i), wv[i]);
        wr(8'h31, 16'h8000);
        wr(8'h36, 16'h0000);
        wr(8'h36, 16'h0080);
        rc(8'h11, 16'h0014);
        rc(8'h16, 16'h0009);
        foreach (rv[i]) rc(8'h35 - 8'(i * 5), 16'h0000);
        rc(8'h40, 16'h0000);
        @(posedge clock);
        reg_addr  <= 8'h35;
        reg_wdata <= 16'h1234;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        reg_addr <= 8'h15;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, 16'h1234);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rc(8'h10, 16'h0032);
        factory();
        rc(8'h10, 16'hFF9C);
        $display("t_map done");
    endtask

    task automatic t_sample();
        wr(8'h35, 16'h0005);
        smp(16'h0030, 16'h001A);
        rc(8'h00, 16'h002B);
        rc(8'h01, 16'h001A);
        smp(16'h8000, 16'h001A);
        rc(8'h00, 16'h8000);
        wr(8'h35, 16'h0000);
        $display("t_sample done");
    endtask

    task automatic t_modes();
        step(16'h0096, 1'b1);
        step(16'h005F, 1'b1);
        step(16'h005A, 1'b0);
        step(16'hFF6A, 1'b1);
        step(16'hFFA1, 1'b1);
        step(16'hFFA6, 1'b0);
        wr(8'h37, 16'h0001);
        wr(8'h30, 16'h0032);
        wr(8'h31, 16'h0014);
        step(16'h003C, 1'b1);
        step(16'h0028, 1'b1);
        step(16'h001E, 1'b0);
        step(16'hFFC4, 1'b0);
        wr(8'h37, 16'h0002);
        wr(8'h30, 16'h000A);
        wr(8'h31, 16'h001E);
        step(16'h0014, 1'b1);
        step(16'hFFF6, 1'b1);
        step(16'hFFEC, 1'b0);
        factory();
        $display("t_modes done");
    endtask

    task automatic t_invert_irq();
        step(16'h0000, 1'b0);
        wr(8'h34, 16'h0001);
        repeat (4) @(posedge clock);
        chk({15'h0000, thr_out}, 16'h0001);
        step(16'h0096, 1'b0);
        wr(8'h34, 16'h0000);
        step(16'h0000, 1'b0);
        wr(8'h08, 16'h0007);
        wr(8'h09, 16'h0001);
        #1 chk({15'h0000, irq}, 16'h0000);
        step(16'h0096, 1'b1);
        chk({15'h0000, irq}, 16'h0001);
        rc(8'h08, 16'h0005);
        wr(8'h08, 16'h0001);
        #1 chk({15'h0000, irq}, 16'h0000);
        rc(8'h08, 16'h0004);
        $display("t_invert_irq done");
    endtask

    task automatic t_filter();
        // settle the reading at zero so the filter steps start from a known value
        smp(16'h0000, 16'h0019);
        rc(8'h00, 16'h0000);
        wr(8'h36, 16'h0002);
        smp(16'h0064, 16'h0019);
        rc(8'h00, 16'h0032);
        smp(16'h0064, 16'h0019);
        rc(8'h00, 16'h004B);
        wr(8'h36, 16'h0001);
        smp(16'h0064, 16'h0019);
        rc(8'h00, 16'h0064);
        // with the clock enable low a whole sample must pass unseen
        @(posedge clock);
        clk_en <= 1'b0;
        smp(16'h0000, 16'h0019);
        clk_en <= 1'b1;
        rc(8'h00, 16'h0064);
        $display("t_filter done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        mismatches  = 0;
        checks_done = 0;
        rstn      = 1'b0;
        por_n     = 1'b0;
        clk_en    = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (10) @(posedge clock);
        rstn  <= 1'b1;
        por_n <= 1'b1;
        t_map();
        t_sample();
        t_modes();
        t_invert_irq();
        t_filter();
        end_of_test();
    end

    // the whole sequence needs well under 10 000 clock cycles
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
endmodule

bind mtc_core mtc_core_monitor #(.DW(DW), .AW(AW)) i_mtc_core_monitor (.clock(clock),
    .rstn(rstn), .por_n(por_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_clk(sample_clk), .field_raw(field_raw), .temp_raw(temp_raw),
    .thr_out(thr_out), .irq(irq));

`default_nettype wire

// ===== sim/mtc_sensor_model.sv
/*
 * far side of the sample link: the sensing front end that presents a raw
 * field and temperature word around each rising edge of its sample clock.
 * assumes the bench calls frame once per sample; the clock stands still between.
 */
`default_nettype none

module mtc_sensor_model (
    output logic        sample_clk,
    output logic [15:0] field_raw,
    output logic [15:0] temp_raw
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sample_clk = 1'b0;
        field_raw  = 16'h0000;
        temp_raw   = 16'h0000;
    end

    // one 64 ns period; words are 16-bit two's complement
    task automatic frame(input logic [15:0] f, input logic [15:0] t);
        #1.7;
        field_raw = f;
        temp_raw  = t;
        #16 sample_clk = 1'b1;
        #32 sample_clk = 1'b0;
        // hold has run out: show the inverse so stale data cannot pass as valid
        #16 field_raw = ~f;
        temp_raw = ~t;
    endtask
endmodule

`default_nettype wire
